/* hdl/cru_pkg.sv */
// Constants for the call, return, compare and skip execution slice
package cru_pkg;
   // ==========================================================
   // Widths
   // ==========================================================
   localparam int PC_WIDTH = 22; // Program counter width in words
   localparam int CNT_WIDTH = 3; // Cycle counter width

   // ==========================================================
   // Exact opcodes
   // ==========================================================
   localparam logic [15:0] OP_INDIRECT_ENTRY = 16'h9509;
   localparam logic [15:0] OP_EXT_INDIRECT_ENTRY = 16'h9519;
   localparam logic [15:0] OP_SUB_EXIT = 16'h9508;
   localparam logic [15:0] OP_INT_EXIT = 16'h9518;

   // ==========================================================
   // Masked opcodes (match when (word & mask) == value)
   // ==========================================================
   localparam logic [15:0] MSK_ABS_ENTRY = 16'hfe0e;
   localparam logic [15:0] VAL_ABS_ENTRY = 16'h940e;
   localparam logic [15:0] MSK_ABS_JUMP = 16'hfe0e;
   localparam logic [15:0] VAL_ABS_JUMP = 16'h940c;
   localparam logic [15:0] MSK_DIRECT_MEM = 16'hfc0f;
   localparam logic [15:0] VAL_DIRECT_MEM = 16'h9000;
   localparam logic [15:0] MSK_RR_OP = 16'hfc00;
   localparam logic [15:0] VAL_CMP_SKIP_EQ = 16'h1000;
   localparam logic [15:0] VAL_REG_CMP = 16'h1400;
   localparam logic [15:0] VAL_CMP_BORROW = 16'h0400;
   localparam logic [15:0] MSK_CMP_IMM = 16'hf000;
   localparam logic [15:0] VAL_CMP_IMM = 16'h3000;
   localparam logic [15:0] MSK_REG_BIT = 16'hfe08;
   localparam logic [15:0] VAL_REG_BIT_CLR = 16'hfc00;
   localparam logic [15:0] VAL_REG_BIT_SET = 16'hfe00;
   localparam logic [15:0] MSK_IO_BIT = 16'hff00;
   localparam logic [15:0] VAL_IO_BIT_CLR = 16'h9900;
   localparam logic [15:0] VAL_IO_BIT_SET = 16'h9b00;
   localparam logic [15:0] MSK_FLAG_BR = 16'hfc00;
   localparam logic [15:0] VAL_FLAG_SET_BR = 16'hf000;
   localparam logic [15:0] VAL_FLAG_CLR_BR = 16'hf400;

   // ==========================================================
   // Status word bit positions
   // ==========================================================
   localparam int FLAG_C = 0;
   localparam int FLAG_Z = 1;
   localparam int FLAG_N = 2;
   localparam int FLAG_V = 3;
   localparam int FLAG_S = 4;
   localparam int FLAG_H = 5;
   localparam int FLAG_I = 7;

   // ==========================================================
   // Cycle counts
   // ==========================================================
   localparam logic [2:0] CYC_INDIRECT = 3'h4;
   localparam logic [2:0] CYC_ABS_ENTRY = 3'h5;
   localparam logic [2:0] CYC_EXIT = 3'h5;
   localparam logic [2:0] CYC_ONE = 3'h1;
   localparam logic [2:0] CYC_TWO = 3'h2;
   localparam logic [2:0] CYC_THREE = 3'h3;

   // ==========================================================
   // Reset values
   // ==========================================================
   localparam logic [7:0] RST_FLAGS = 8'h00;
endpackage : cru_pkg

/* hdl/cru_sub.sv */
// Eight-bit compare subtractor producing the arithmetic status flags
module cru_sub (
   input wire logic [7:0] a_i,
   input wire logic [7:0] b_i,
   input wire logic cin_i,
   input wire logic zin_i,
   input wire logic chain_i,
   output logic [7:0] flags_o
);
   // ==========================================================
   // Difference and borrows
   // ==========================================================
   logic [7:0] diff; // Discarded result
   logic [7:0] brw; // Borrow out of each bit
   logic n_flag; // Sign of the result
   logic v_flag; // Two's complement overflow

   // Bit-wise borrow chain, flags packed at their status positions
   always_comb begin
      diff = a_i - b_i - {7'h00, cin_i};
      brw = (~a_i & b_i) | (b_i & diff) | (diff & ~a_i);
      n_flag = diff[7];
      v_flag = (a_i[7] & ~b_i[7] & ~diff[7]) | (~a_i[7] & b_i[7] & diff[7]);
      flags_o = 8'h00;
      flags_o[cru_pkg::FLAG_C] = brw[7];
      flags_o[cru_pkg::FLAG_H] = brw[3];
      flags_o[cru_pkg::FLAG_N] = n_flag;
      flags_o[cru_pkg::FLAG_V] = v_flag;
      flags_o[cru_pkg::FLAG_S] = n_flag ^ v_flag;
      // Chained compares keep zero only if the earlier byte was zero too
      if (chain_i) begin
         flags_o[cru_pkg::FLAG_Z] = (diff == 8'h00) & zin_i;
      end else begin
         flags_o[cru_pkg::FLAG_Z] = (diff == 8'h00);
      end
   end
endmodule : cru_sub

/* hdl/cru_len.sv */
// Length detector telling whether an instruction word starts a two-word instruction
module cru_len (
   input wire logic [15:0] word_i,
   output logic two_word_o
);
   // Absolute jump, absolute call and direct memory load/store carry a second word
   always_comb begin
      two_word_o = ((word_i & cru_pkg::MSK_ABS_JUMP) == cru_pkg::VAL_ABS_JUMP)
         | ((word_i & cru_pkg::MSK_ABS_ENTRY) == cru_pkg::VAL_ABS_ENTRY)
         | ((word_i & cru_pkg::MSK_DIRECT_MEM) == cru_pkg::VAL_DIRECT_MEM);
   end
endmodule : cru_len

/* hdl/cru_core.sv */
// Execution sequencer for calls, returns, compares, skips and flag branches
module cru_core #(
   parameter int PC_W = cru_pkg::PC_WIDTH
) (
   input wire logic CLOCK_I,
   input wire logic RST_N_I,
   input wire logic START_I,
   input wire logic [15:0] INSTR_I,
   input wire logic [15:0] NEXT_WORD_I,
   input wire logic [15:0] FOLLOW_WORD_I,
   input wire logic [PC_W-1:0] PC_I,
   input wire logic [15:0] Z_PTR_I,
   input wire logic [7:0] EXT_PAGE_I,
   input wire logic [7:0] RD_DATA_I,
   input wire logic [7:0] RR_DATA_I,
   input wire logic [7:0] IO_DATA_I,
   input wire logic [7:0] FLAGS_I,
   input wire logic [PC_W-1:0] STACK_PC_I,
   output logic BUSY_O,
   output logic DONE_O,
   output logic IGNORED_O,
   output logic PC_LOAD_O,
   output logic [PC_W-1:0] PC_NEW_O,
   output logic FLAGS_WE_O,
   output logic [7:0] FLAGS_NEW_O,
   output logic PUSH_O,
   output logic [PC_W-1:0] PUSH_PC_O,
   output logic POP_O
);
   // ==========================================================
   // Elaboration checks
   // ==========================================================
   // The extended pointer is 24 bits; a counter narrower than Z is useless
   if (PC_W < 16 || PC_W > 24) begin : g_bad_width
      $error("PC_W must be 16 to 24");
   end

   // ==========================================================
   // State
   // ==========================================================
   typedef struct packed {
      logic busy; // Multi-cycle instruction in progress
      logic [cru_pkg::CNT_WIDTH-1:0] remain; // Cycles left before completion
      logic from_stack; // Final target comes from the stack
      logic done; // Completion pulse
      logic ignored; // Unsupported or refused word pulse
      logic pc_load; // Counter load strobe
      logic [PC_W-1:0] pc_new; // Target address
      logic flags_we; // Status write strobe
      logic flags_pend; // Status write owed at completion
      logic [7:0] flags_new; // Status word to write
      logic push; // Return address push pulse
      logic [PC_W-1:0] push_pc; // Return address
      logic pop; // Return address pop pulse
   } cru_state_s;

   cru_state_s cur; // Registered state
   cru_state_s next_cur; // Next state

   // ==========================================================
   // Decode helpers
   // ==========================================================
   localparam logic [7:0] FLAG_KEEP = 8'hc0; // Bits a compare keeps: I and T
   logic follow_two; // Skipped instruction is two words long
   logic [7:0] cmp_flags; // Flags from the shared subtractor
   logic [7:0] cmp_b; // Subtrahend: register or immediate
   logic cmp_cin; // Borrow in for the chained compare
   logic is_chain; // Compare-with-borrow selected

   logic is_ind; // Indirect subroutine entry
   logic is_ext; // Extended indirect subroutine entry
   logic is_abs; // Absolute subroutine entry
   logic is_sub_exit; // Subroutine exit
   logic is_int_exit; // Interrupt exit
   logic is_cse; // Compare and skip if equal
   logic is_cmp; // Register compare
   logic is_cmp_imm; // Immediate compare
   logic is_rb_clr; // Register bit clear skip
   logic is_rb_set; // Register bit set skip
   logic is_io_clr; // I/O bit clear skip
   logic is_io_set; // I/O bit set skip
   logic is_br_set; // Flag set branch
   logic is_br_clr; // Flag clear branch

   logic [2:0] bit_sel; // Selected bit index in the low three bits
   logic [PC_W-1:0] pc_seq; // Counter plus one
   logic [PC_W-1:0] pc_skip; // Counter past the skipped instruction
   logic [2:0] skip_cyc; // Cycles of a taken skip
   logic [PC_W-1:0] pc_branch; // Counter plus offset plus one
   logic [PC_W-1:0] abs_target; // Address embedded in the call
   logic [PC_W-1:0] ext_target; // Page and Z pointer joined
   logic [23:0] abs_wide; // Embedded address before fitting
   logic [23:0] ext_wide; // Page:Z before fitting

   // Instruction-class decode from the first word
   always_comb begin
      is_ind = INSTR_I == cru_pkg::OP_INDIRECT_ENTRY;
      is_ext = INSTR_I == cru_pkg::OP_EXT_INDIRECT_ENTRY;
      is_abs = (INSTR_I & cru_pkg::MSK_ABS_ENTRY) == cru_pkg::VAL_ABS_ENTRY;
      is_sub_exit = INSTR_I == cru_pkg::OP_SUB_EXIT;
      is_int_exit = INSTR_I == cru_pkg::OP_INT_EXIT;
      is_cse = (INSTR_I & cru_pkg::MSK_RR_OP) == cru_pkg::VAL_CMP_SKIP_EQ;
      is_cmp = (INSTR_I & cru_pkg::MSK_RR_OP) == cru_pkg::VAL_REG_CMP;
      is_chain = (INSTR_I & cru_pkg::MSK_RR_OP) == cru_pkg::VAL_CMP_BORROW;
      is_cmp_imm = (INSTR_I & cru_pkg::MSK_CMP_IMM) == cru_pkg::VAL_CMP_IMM;
      is_rb_clr = (INSTR_I & cru_pkg::MSK_REG_BIT) == cru_pkg::VAL_REG_BIT_CLR;
      is_rb_set = (INSTR_I & cru_pkg::MSK_REG_BIT) == cru_pkg::VAL_REG_BIT_SET;
      is_io_clr = (INSTR_I & cru_pkg::MSK_IO_BIT) == cru_pkg::VAL_IO_BIT_CLR;
      is_io_set = (INSTR_I & cru_pkg::MSK_IO_BIT) == cru_pkg::VAL_IO_BIT_SET;
      is_br_set = (INSTR_I & cru_pkg::MSK_FLAG_BR) == cru_pkg::VAL_FLAG_SET_BR;
      is_br_clr = (INSTR_I & cru_pkg::MSK_FLAG_BR) == cru_pkg::VAL_FLAG_CLR_BR;
      bit_sel = INSTR_I[2:0];
   end

   // Address arithmetic shared by all paths
   always_comb begin
      pc_seq = PC_I + PC_W'(1);
      if (follow_two) begin
         pc_skip = PC_I + PC_W'(3);
         skip_cyc = cru_pkg::CYC_THREE;
      end else begin
         pc_skip = PC_I + PC_W'(2);
         skip_cyc = cru_pkg::CYC_TWO;
      end
      // Seven-bit signed offset, sign extended to the counter width
      pc_branch = pc_seq + {{(PC_W-7){INSTR_I[9]}}, INSTR_I[9:3]};
      abs_wide = {2'b00, INSTR_I[8:4], INSTR_I[0], NEXT_WORD_I};
      abs_target = abs_wide[PC_W-1:0];
      ext_wide = {EXT_PAGE_I, Z_PTR_I};
      ext_target = ext_wide[PC_W-1:0];
   end

   // Subtrahend: immediate or register
   always_comb begin
      if (is_cmp_imm) begin
         cmp_b = {INSTR_I[11:8], INSTR_I[3:0]};
      end else begin
         cmp_b = RR_DATA_I;
      end
      cmp_cin = is_chain & FLAGS_I[cru_pkg::FLAG_C];
   end

   // ==========================================================
   // Leaf instances
   // ==========================================================
   cru_sub u_sub (
      .a_i(RD_DATA_I),
      .b_i(cmp_b),
      .cin_i(cmp_cin),
      .zin_i(FLAGS_I[cru_pkg::FLAG_Z]),
      .chain_i(is_chain),
      .flags_o(cmp_flags)
   );

   cru_len u_len (
      .word_i(FOLLOW_WORD_I),
      .two_word_o(follow_two)
   );

   // ==========================================================
   // Next-state logic
   // ==========================================================
   // Pulses drop every cycle; a start is only taken while idle
   always_comb begin
      next_cur = cur;
      next_cur.done = 1'b0;
      next_cur.ignored = 1'b0;
      next_cur.pc_load = 1'b0;
      next_cur.flags_we = 1'b0;
      next_cur.push = 1'b0;
      next_cur.pop = 1'b0;
      if (cur.busy) begin
         // Count down; the last step lets the target out
         if (cur.remain == cru_pkg::CYC_ONE) begin
            next_cur.busy = 1'b0;
            next_cur.done = 1'b1;
            next_cur.pc_load = 1'b1;
            if (cur.from_stack) begin
               next_cur.pc_new = STACK_PC_I;
            end
            next_cur.flags_we = cur.flags_pend;
         end
         next_cur.remain = cur.remain - cru_pkg::CYC_ONE;
         if (START_I) begin
            // A new word during a long instruction is refused
            next_cur.ignored = 1'b1;
         end
      end else if (START_I) begin
         next_cur.flags_new = FLAGS_I;
         next_cur.from_stack = 1'b0;
         next_cur.flags_pend = is_int_exit;
         next_cur.pc_new = pc_seq;
         if (is_ind || is_ext || is_abs) begin
            // Calls push the return address at once and load late
            next_cur.busy = 1'b1;
            next_cur.push = 1'b1;
            if (is_abs) begin
               next_cur.remain = cru_pkg::CYC_ABS_ENTRY - 3'h1;
               next_cur.push_pc = PC_I + PC_W'(2);
               next_cur.pc_new = abs_target;
            end else begin
               next_cur.remain = cru_pkg::CYC_INDIRECT - 3'h1;
               next_cur.push_pc = pc_seq;
               if (is_ext) begin
                  next_cur.pc_new = ext_target;
               end else begin
                  next_cur.pc_new = PC_W'(Z_PTR_I);
               end
            end
         end else if (is_sub_exit || is_int_exit) begin
            // Returns pop now and take the address at the last step
            next_cur.busy = 1'b1;
            next_cur.pop = 1'b1;
            next_cur.from_stack = 1'b1;
            next_cur.remain = cru_pkg::CYC_EXIT - 3'h1;
            next_cur.flags_new[cru_pkg::FLAG_I] |= is_int_exit;
         end else if (is_cmp || is_chain || is_cmp_imm) begin
            // Compares write flags only, never a result
            next_cur.done = 1'b1;
            next_cur.pc_load = 1'b1;
            next_cur.flags_we = 1'b1;
            next_cur.flags_new = (FLAGS_I & FLAG_KEEP) | (cmp_flags & ~FLAG_KEEP);
         end else if ((is_cse && RD_DATA_I == RR_DATA_I)
               || (is_rb_clr && !RR_DATA_I[bit_sel])
               || (is_rb_set && RR_DATA_I[bit_sel])
               || (is_io_clr && !IO_DATA_I[bit_sel])
               || (is_io_set && IO_DATA_I[bit_sel])) begin
            // Taken skip: two or three cycles, flags untouched
            next_cur.busy = 1'b1;
            next_cur.remain = skip_cyc - 3'h1;
            next_cur.pc_new = pc_skip;
         end else if ((is_br_set && FLAGS_I[bit_sel])
               || (is_br_clr && !FLAGS_I[bit_sel])) begin
            // Taken branch costs one extra cycle
            next_cur.busy = 1'b1;
            next_cur.remain = cru_pkg::CYC_TWO - 3'h1;
            next_cur.pc_new = pc_branch;
         end else if (is_cse || is_rb_clr || is_rb_set || is_io_clr || is_io_set
               || is_br_set || is_br_clr) begin
            // Untaken skip or branch: sequential in one cycle
            next_cur.done = 1'b1;
            next_cur.pc_load = 1'b1;
         end else begin
            // Word outside this slice: refused
            next_cur.ignored = 1'b1;
         end
      end
   end

   // ==========================================================
   // State register
   // ==========================================================
   // Synchronous reset to an idle machine with all strobes low
   always_ff @(posedge CLOCK_I) begin
      if (!RST_N_I) begin
         cur <= '0;
         cur.flags_new <= cru_pkg::RST_FLAGS;
      end else begin
         cur <= next_cur;
      end
   end

   // ==========================================================
   // Outputs, straight from the state register
   // ==========================================================
   assign BUSY_O = cur.busy;
   assign DONE_O = cur.done;
   assign IGNORED_O = cur.ignored;
   assign PC_LOAD_O = cur.pc_load;
   assign PC_NEW_O = cur.pc_new;
   assign FLAGS_WE_O = cur.flags_we;
   assign FLAGS_NEW_O = cur.flags_new;
   assign PUSH_O = cur.push;
   assign PUSH_PC_O = cur.push_pc;
   assign POP_O = cur.pop;
endmodule : cru_core

/* testbench/cru_core_asserts.sv */
// Port checks for the call, return, compare and skip slice
module cru_core_asserts #(
   parameter int PC_W = 22
) (
   input wire logic CLOCK_I,
   input wire logic RST_N_I,
   input wire logic START_I,
   input wire logic [15:0] INSTR_I,
   input wire logic [15:0] NEXT_WORD_I,
   input wire logic [15:0] FOLLOW_WORD_I,
   input wire logic [PC_W-1:0] PC_I,
   input wire logic [15:0] Z_PTR_I,
   input wire logic [7:0] RD_DATA_I,
   input wire logic [7:0] RR_DATA_I,
   input wire logic [7:0] FLAGS_I,
   input wire logic [PC_W-1:0] STACK_PC_I,
   input wire logic BUSY_O,
   input wire logic DONE_O,
   input wire logic [PC_W-1:0] PC_NEW_O,
   input wire logic FLAGS_WE_O,
   input wire logic [7:0] FLAGS_NEW_O,
   input wire logic PUSH_O,
   input wire logic [PC_W-1:0] PUSH_PC_O,
   input wire logic POP_O
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========
   // Helpers
   // ==========
   default clocking dc @(posedge CLOCK_I); endclocking
   default disable iff (!RST_N_I);
   logic take; // Request accepted at this edge
   logic [PC_W-1:0] pc1; // Address of the following word
   logic [PC_W-1:0] abs_tgt; // Target carried by an absolute call
   logic [PC_W-1:0] br_tgt; // Branch target, offset sign extended
   assign take = START_I && !BUSY_O;
   assign pc1 = PC_I + 1'b1;
   assign abs_tgt = PC_W'({INSTR_I[8:4], INSTR_I[0], NEXT_WORD_I});
   assign br_tgt = PC_I + PC_W'(signed'(INSTR_I[9:3])) + 1'b1;
   // Accepted word, masked opcode, operand condition
   sequence s_op(logic [15:0] m, logic [15:0] v, logic c);
      take && ((INSTR_I & m) == v) && c;
   endsequence
   // Three cycles without completion
   sequence s_idle3;
      !DONE_O [*3];
   endsequence
   // ==========
   // Properties
   // ==========
   AST_IND: assert property (
      s_op(16'hffff, cru_pkg::OP_INDIRECT_ENTRY, 1'b1) |=> (PUSH_O && PUSH_PC_O == $past(pc1))
      ##3 (DONE_O && PC_NEW_O == PC_W'($past(Z_PTR_I, 4))))
      else $error("indirect entry wrong");
   AST_CALL: assert property (
      s_op(cru_pkg::MSK_ABS_ENTRY, cru_pkg::VAL_ABS_ENTRY, 1'b1) |=> PUSH_O ##1 s_idle3
      ##1 (DONE_O && !FLAGS_WE_O && PC_NEW_O == $past(abs_tgt, 5)))
      else $error("absolute entry wrong");
   AST_EXIT: assert property (
      s_op(16'hffff, cru_pkg::OP_SUB_EXIT, 1'b1) |=> (POP_O && !DONE_O) ##1 s_idle3
      ##1 (DONE_O && !FLAGS_WE_O && PC_NEW_O == $past(STACK_PC_I)))
      else $error("subroutine exit wrong");
   AST_IEXIT: assert property (
      s_op(16'hffff, cru_pkg::OP_INT_EXIT, 1'b1) |=> POP_O ##1 s_idle3
      ##1 (DONE_O && FLAGS_WE_O && FLAGS_NEW_O[7]))
      else $error("interrupt exit wrong");
   AST_CMP: assert property (
      s_op(cru_pkg::MSK_RR_OP, cru_pkg::VAL_REG_CMP, 1'b1) |=> DONE_O && FLAGS_WE_O
      && PC_NEW_O == $past(pc1) && FLAGS_NEW_O[1] == ($past(RD_DATA_I) == $past(RR_DATA_I))
      && FLAGS_NEW_O[0] == ($past(RD_DATA_I) < $past(RR_DATA_I)))
      else $error("register compare wrong");
   AST_CSE_NE: assert property (
      s_op(cru_pkg::MSK_RR_OP, cru_pkg::VAL_CMP_SKIP_EQ, RD_DATA_I != RR_DATA_I)
      |=> DONE_O && !FLAGS_WE_O && PC_NEW_O == $past(pc1))
      else $error("unequal skip taken");
   AST_SKIP3: assert property (
      s_op(cru_pkg::MSK_RR_OP, cru_pkg::VAL_CMP_SKIP_EQ, RD_DATA_I == RR_DATA_I
      && (FOLLOW_WORD_I & cru_pkg::MSK_ABS_ENTRY) == cru_pkg::VAL_ABS_ENTRY)
      |=> !DONE_O ##1 !DONE_O ##1 (DONE_O && PC_NEW_O == $past(pc1, 3) + 2'h2))
      else $error("two-word skip wrong");
   AST_BSET_NO: assert property (
      s_op(cru_pkg::MSK_FLAG_BR, cru_pkg::VAL_FLAG_SET_BR, !FLAGS_I[INSTR_I[2:0]])
      |=> DONE_O && PC_NEW_O == $past(pc1))
      else $error("flag-set branch wrong");
   AST_BCLR_GO: assert property (
      s_op(cru_pkg::MSK_FLAG_BR, cru_pkg::VAL_FLAG_CLR_BR, !FLAGS_I[INSTR_I[2:0]])
      |=> !DONE_O ##1 (DONE_O && !FLAGS_WE_O && PC_NEW_O == $past(br_tgt, 2)))
      else $error("flag-clear branch wrong");
endmodule : cru_core_asserts

bind cru_core cru_core_asserts #(.PC_W(PC_W)) u_chk (
   .CLOCK_I(CLOCK_I), .RST_N_I(RST_N_I), .START_I(START_I), .INSTR_I(INSTR_I),
   .NEXT_WORD_I(NEXT_WORD_I), .FOLLOW_WORD_I(FOLLOW_WORD_I), .PC_I(PC_I), .Z_PTR_I(Z_PTR_I),
   .RD_DATA_I(RD_DATA_I), .RR_DATA_I(RR_DATA_I), .FLAGS_I(FLAGS_I), .STACK_PC_I(STACK_PC_I),
   .BUSY_O(BUSY_O), .DONE_O(DONE_O), .PC_NEW_O(PC_NEW_O), .FLAGS_WE_O(FLAGS_WE_O),
   .FLAGS_NEW_O(FLAGS_NEW_O), .PUSH_O(PUSH_O), .PUSH_PC_O(PUSH_PC_O), .POP_O(POP_O));

/* testbench/cru_mem.sv */
// Behavioural register file, I/O space, status word and return stack
module cru_mem #(
   parameter int PC_W = 22
) (
   input wire logic clk_i,
   input wire logic [15:0] instr_i,
   input wire logic push_i,
   input wire logic [PC_W-1:0] push_pc_i,
   input wire logic pop_i,
   input wire logic flags_we_i,
   input wire logic [7:0] flags_new_i,
   output logic [7:0] rd_o,
   output logic [7:0] rr_o,
   output logic [7:0] io_o,
   output logic [7:0] flags_o,
   output logic [PC_W-1:0] stack_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========
   // Storage, loaded by the bench
   // ==========
   logic [7:0] gpr [32]; // Working registers
   logic [7:0] io [32]; // Bit addressable I/O registers
   logic [PC_W-1:0] stk [16]; // Return addresses
   int sp = 0; // Next free stack slot
   // Immediate compare reaches only the upper sixteen registers
   assign rd_o = gpr[instr_i[15:12] == 4'h3 ? {1'b1, instr_i[7:4]} : instr_i[8:4]];
   // Bit skips name the tested register in the destination field
   assign rr_o = gpr[instr_i[15:12] == 4'hf ? instr_i[8:4] : {instr_i[9], instr_i[3:0]}];
   assign io_o = io[instr_i[7:3]];
   // Popped value latched early, steady by the last busy cycle
   always @(posedge clk_i) begin
      if (push_i) begin
         stk[sp] <= push_pc_i;
         sp <= sp + 1;
      end
      if (pop_i) begin
         stack_o <= stk[sp-1];
         sp <= sp - 1;
      end
      if (flags_we_i) flags_o <= flags_new_i;
   end
endmodule : cru_mem

/* testbench/cru_core_tb.sv */
// Self-checking bench for the execution slice
module cru_core_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int PW = 22; // Program counter width used here
   logic clk = 1'b0, rst_n = 1'b0, start = 1'b0;
   logic [15:0] instr = 16'h0, next_w = 16'h0, follow = 16'h0, z = 16'h0;
   logic [7:0] page = 8'h0;
   logic [PW-1:0] pc = '0;
   logic busy, done, pc_ld, fwe, push, pop, ign;
   logic [7:0] rd, rr, io, flags, fnew;
   logic [PW-1:0] pc_new, push_pc, stk;
   int n_fail = 0, checks = 0;

   // ==========
   // Design and partner
   // ==========
   cru_core #(.PC_W(PW)) DUT (.CLOCK_I(clk), .RST_N_I(rst_n), .START_I(start),
      .INSTR_I(instr), .NEXT_WORD_I(next_w), .FOLLOW_WORD_I(follow), .PC_I(pc), .Z_PTR_I(z),
      .EXT_PAGE_I(page), .RD_DATA_I(rd), .RR_DATA_I(rr), .IO_DATA_I(io), .FLAGS_I(flags),
      .STACK_PC_I(stk), .BUSY_O(busy), .DONE_O(done), .IGNORED_O(ign), .PC_LOAD_O(pc_ld),
      .PC_NEW_O(pc_new), .FLAGS_WE_O(fwe), .FLAGS_NEW_O(fnew), .PUSH_O(push),
      .PUSH_PC_O(push_pc), .POP_O(pop));
   cru_mem #(.PC_W(PW)) u_mem (.clk_i(clk), .instr_i(instr), .push_i(push),
      .push_pc_i(push_pc), .pop_i(pop), .flags_we_i(fwe), .flags_new_i(fnew), .rd_o(rd),
      .rr_o(rr), .io_o(io), .flags_o(flags), .stack_o(stk));

   // ==========
   // Shared tasks
   // ==========
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   // Issue one word at a falling edge, count cycles to completion
   task automatic run(input logic [15:0] op, input logic [15:0] fw, output int n);
      instr = op;
      follow = fw;
      start = 1'b1;
      @(negedge clk);
      start = 1'b0;
      n = 1;
      while (done !== 1'b1 && n < 8) begin
         @(negedge clk);
         n++;
      end
      chk({ign, busy, pc_ld, done}, 32'h3);
      // One idle cycle so start is never set twice in one time step
      @(negedge clk);
   endtask : run
   // Expected flags: chained form borrows C, keeps Z only if set
   function automatic logic [7:0] cmpf(input logic [7:0] a, input logic [7:0] b,
      input logic chain, input logic [7:0] f);
      logic [8:0] r;
      logic [7:0] o;
      r = {1'b0, a} - {1'b0, b} - (chain & f[0]);
      o = f;
      o[0] = r[8];
      o[1] = (r[7:0] == 8'h0) && (!chain || f[1]);
      o[2] = r[7];
      o[3] = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
      o[4] = o[2] ^ o[3];
      o[5] = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
      return o;
   endfunction : cmpf

   // ==========
   // Scenarios
   // ==========
   task automatic t_calls();
      int n;
      u_mem.flags_o = 8'h2a;
      pc = 22'h100;
      next_w = 16'h1234;
      run(16'h941f, 16'h0, n);
      chk(n, 5);
      chk(pc_new, 32'h31234);
      run(cru_pkg::OP_SUB_EXIT, 16'h0, n);
      chk(n, 5);
      chk(pc_new, 32'h102);
      chk(flags, 8'h2a);
      u_mem.flags_o = 8'h00;
      pc = 22'h200;
      z = 16'h0abc;
      run(cru_pkg::OP_INDIRECT_ENTRY, 16'h0, n);
      chk(n, 4);
      chk(pc_new, 32'h0abc);
      pc = 22'h300;
      page = 8'h02;
      run(cru_pkg::OP_EXT_INDIRECT_ENTRY, 16'h0, n);
      chk(n, 4);
      chk(pc_new, 32'h20abc);
      chk(flags, 8'h00);
      run(cru_pkg::OP_INT_EXIT, 16'h0, n);
      chk(n, 5);
      chk(pc_new, 32'h301);
      chk(flags, 8'h80);
      run(cru_pkg::OP_SUB_EXIT, 16'h0, n);
      chk(pc_new, 32'h201);
      $display("calls done");
   endtask : t_calls

   task automatic t_cmp();
      logic [7:0] a [4] = '{8'h05, 8'h00, 8'h80, 8'h10};
      logic [7:0] b [4] = '{8'h05, 8'h01, 8'h01, 8'h01};
      int n;
      pc = 22'h40;
      for (int i = 0; i < 4; i++) begin
         u_mem.gpr[1] = a[i];
         u_mem.gpr[2] = b[i];
         u_mem.gpr[16] = a[i];
         u_mem.flags_o = 8'h03;
         run(16'h1412, 16'h0, n);
         chk(fnew, cmpf(a[i], b[i], 1'b0, 8'h03));
         chk(n, 1);
         chk(pc_new, 32'h41);
         u_mem.flags_o = 8'h03;
         run(16'h0412, 16'h0, n);
         chk(fnew, cmpf(a[i], b[i], 1'b1, 8'h03));
         u_mem.flags_o = 8'h01;
         run(16'h0412, 16'h0, n);
         chk(fnew, cmpf(a[i], b[i], 1'b1, 8'h01));
         u_mem.flags_o = 8'h03;
         run({4'h3, b[i][7:4], 4'h0, b[i][3:0]}, 16'h0, n);
         chk(fnew, cmpf(a[i], b[i], 1'b0, 8'h03));
         chk(n, 1);
      end
      $display("compares done");
   endtask : t_cmp

   task automatic t_skip();
      logic [15:0] op [8] = '{16'h1012, 16'h1013, 16'hfc13, 16'hfc12, 16'hfe13, 16'h9922,
         16'h9b22, 16'h9921};
      logic [7:0] hit = 8'hd9; // Bit i set: op i skips
      int n;
      u_mem.gpr[1] = 8'h08;
      u_mem.gpr[2] = 8'h08;
      u_mem.gpr[3] = 8'h00;
      u_mem.io[4] = 8'h04;
      u_mem.flags_o = 8'h55;
      pc = 22'h80;
      for (int i = 0; i < 8; i++) begin
         run(op[i], 16'h0000, n);
         chk(n, hit[i] ? 2 : 1);
         chk(pc_new, hit[i] ? 32'h82 : 32'h81);
         run(op[i], 16'h940e, n);
         chk(n, hit[i] ? 3 : 1);
         chk(pc_new, hit[i] ? 32'h83 : 32'h81);
      end
      chk(flags, 8'h55);
      $display("skips done");
   endtask : t_skip

   task automatic t_branch();
      logic [15:0] op [4] = '{16'hf029, 16'hf028, 16'hf7e8, 16'hf429};
      logic [31:0] tgt [4] = '{32'h106, 32'h101, 32'hfe, 32'h101};
      int n;
      u_mem.flags_o = 8'h02;
      pc = 22'h100;
      for (int i = 0; i < 4; i++) begin
         run(op[i], 16'h0, n);
         chk(n, (i % 2 == 0) ? 2 : 1);
         chk(pc_new, tgt[i]);
      end
      chk(flags, 8'h02);
      $display("branches done");
   endtask : t_branch

   // ==========
   // Verdict, clock, watchdog and main sequence
   // ==========
   task automatic close_out();
      $display("checks=%0d n_fail=%0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : close_out

   initial begin
      forever #12.5 clk = ~clk;
   end
   // Scenarios need under a thousand cycles
   initial begin
      repeat (5000) @(posedge clk);
      n_fail++;
      close_out();
   end
   initial begin
      repeat (8) @(posedge clk);
      @(negedge clk);
      rst_n = 1'b1;
      @(negedge clk);
      t_calls();
      t_cmp();
      t_skip();
      t_branch();
      close_out();
   end
endmodule : cru_core_tb
